// *** hw/ubrs_ir_decoder.sv ***
// Infrared receive decoder: one low bit time per falling edge on the pin.
// Assumes an oversampling tick pulse of one system clock, 16 per bit.
module ubrs_ir_decoder (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Receive pin
  input wire logic i_rx,
  // Decoded line
  ubrs_ir_if.dec ir
);

  logic [2:0] sync_r;
  logic filt_r;
  logic pend_r;
  logic low_r;
  logic [3:0] cnt_r;
  logic pend_nxt;
  logic low_nxt;
  logic [3:0] cnt_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Pin filter and edge detect
  wire agree = (sync_r[1] == sync_r[2]);
  wire fall = agree & ~sync_r[2] & filt_r; // R10
  wire last = (cnt_r == ubrs_pkg::IR_LAST_TICK);
  wire start = ir.os_tick & pend_r & (~low_r | last); // R12

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      sync_r <= 3'h7;
      filt_r <= 1'b1;
    end else begin
      sync_r <= {sync_r[1:0], i_rx};
      if (agree) begin
        filt_r <= sync_r[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sixteen-tick low pulse
  assign pend_nxt = fall | (pend_r & ~start); // R11
  assign low_nxt = start | (low_r & ~(ir.os_tick & last)); // R12
  assign cnt_nxt = start ? ubrs_pkg::RST_CNT :
                   (ir.os_tick & low_r) ? cnt_r + 4'h1 : cnt_r;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      pend_r <= 1'b0;
      low_r <= 1'b0;
      cnt_r <= ubrs_pkg::RST_CNT;
    end else begin
      pend_r <= pend_nxt;
      low_r <= low_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign ir.int_rx = ~low_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  property p_ir_start;
    $fell(ir.int_rx) |-> $past(ir.os_tick) && $past(pend_r);
  endproperty
  a_ir_start: assert property (p_ir_start) else $error("Decoded low without edge"); // R11

  property p_ir_len;
    ir.os_tick && low_r && last && !pend_r |=> ir.int_rx;
  endproperty
  a_ir_len: assert property (p_ir_len) else $error("Decoded low not ended"); // R12

  property p_ir_hold;
    low_r && ir.os_tick && !last |=> !ir.int_rx && cnt_r == $past(cnt_r) + 4'h1;
  endproperty
  a_ir_hold: assert property (p_ir_hold) else $error("Decoded low ended early"); // R12

  property p_ir_fall;
    fall |=> pend_r;
  endproperty
  a_ir_fall: assert property (p_ir_fall) else $error("Falling edge lost"); // R10

  c_ir_pulse: cover property ($fell(ir.int_rx) ##[1:400] $rose(ir.int_rx));

endmodule

// *** hw/ubrs_regbank.sv ***
// Banked register select for one UART channel, with infrared receive decode.
// Assumes host bus strobes synchronous to i_sys_clk; base registers outside.
//
// Functional notes
// [R1] Divisor bank maps offsets 0 and 1
// [R2] Bank BF: offset 6 off-one, 4 on-one
// [R3] Bank BF: offset 7 off-two, 5 on-two
// [R4] Bank BF: offset 2 enhanced feature control
// [R5] Enhanced, modem bit: offset 6 threshold
// [R6] Same conditions: offset 7 FIFO triggers
// [R7] Modem change exposes FIFO ready at 7
// [R8] Host restores saved line control afterwards
// [R9] Host sets enhanced bit, then line 00
// [R10] Decoder triggers on falling edges only
// [R11] Positive pulse: zero shows after pulse
// [R12] Edge drives line low sixteen ticks
// [R13] Unmapped offsets fall through to base
module ubrs_regbank (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // Host bus
  input wire logic i_cs_b,
  input wire logic i_wr_b,
  input wire logic i_rd_b,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe,
  // Base register set
  output logic o_base_wr,
  output logic o_base_rd,
  output logic [2:0] o_base_addr,
  input wire logic [7:0] i_base_rdata,
  // FIFO ready state
  input wire logic [7:0] i_fifo_rdy,
  // Configuration to the channel
  output logic [7:0] o_line_control,
  output logic [7:0] o_modem_control,
  output logic [7:0] o_enhanced_feature_ctrl,
  output logic [15:0] o_baud_divisor,
  output logic [7:0] o_flow_on_char_one,
  output logic [7:0] o_flow_on_char_two,
  output logic [7:0] o_flow_off_char_one,
  output logic [7:0] o_flow_off_char_two,
  output logic [7:0] o_flow_threshold_ctrl,
  output logic [7:0] o_fifo_trigger_levels,
  output logic [1:0] o_bank,
  // Infrared receive
  input wire logic i_os_tick,
  input wire logic i_rx,
  output logic o_int_rx
);

  logic [7:0] lcr_r;
  logic [7:0] mcr_r;
  logic [7:0] efr_r;
  logic [7:0] dll_r;
  logic [7:0] dlm_r;
  logic [7:0] on1_r;
  logic [7:0] on2_r;
  logic [7:0] off1_r;
  logic [7:0] off2_r;
  logic [7:0] tcr_r;
  logic [7:0] tlr_r;
  logic [7:0] rdata_r;
  logic oe_r;
  ubrs_pkg::ubrs_bank_t bank;

  ////////////////////////////////////////////////////////////////////////////
  // Bank decode
  function automatic logic hit(input logic en, input logic [2:0] a, input logic [2:0] off);
    hit = en & (a == off);
  endfunction

  wire wr_en = ~i_cs_b & ~i_wr_b;
  wire rd_en = ~i_cs_b & ~i_rd_b & i_wr_b;
  wire lcr_enh = (lcr_r == ubrs_pkg::LCR_ENH_BANK);
  wire lcr_div = lcr_r[ubrs_pkg::LCR_DIV_BIT] & ~lcr_enh;
  wire thr_sel = efr_r[ubrs_pkg::EFR_ENH_BIT] & ~lcr_enh;
  wire thr_bank = thr_sel & mcr_r[ubrs_pkg::MCR_BANK_BIT];
  wire rdy_bank = thr_sel & ~mcr_r[ubrs_pkg::MCR_BANK_BIT];

  always_comb begin
    if (lcr_enh) begin
      bank = ubrs_pkg::UBRS_BANK_ENH;
    end else if (lcr_div) begin
      bank = ubrs_pkg::UBRS_BANK_DIV;
    end else if (thr_bank) begin
      bank = ubrs_pkg::UBRS_BANK_THR;
    end else begin
      bank = ubrs_pkg::UBRS_BANK_BASE;
    end
  end

  wire in_div = (bank == ubrs_pkg::UBRS_BANK_DIV);
  wire in_enh = (bank == ubrs_pkg::UBRS_BANK_ENH);
  wire in_thr = (bank == ubrs_pkg::UBRS_BANK_THR);

  wire sel_lcr = hit(1'b1, i_addr, ubrs_pkg::OFF_LINE_CTRL);
  wire sel_dll = hit(in_div, i_addr, ubrs_pkg::OFF_DIV_LOW); // R1
  wire sel_dlm = hit(in_div, i_addr, ubrs_pkg::OFF_DIV_HIGH); // R1
  wire sel_efr = hit(in_enh, i_addr, ubrs_pkg::OFF_ENH_CTRL); // R4
  wire sel_on1 = hit(in_enh, i_addr, ubrs_pkg::OFF_FLOW_ON_ONE); // R2
  wire sel_off1 = hit(in_enh, i_addr, ubrs_pkg::OFF_FLOW_OFF_ONE); // R2
  wire sel_on2 = hit(in_enh, i_addr, ubrs_pkg::OFF_FLOW_ON_TWO); // R3
  wire sel_off2 = hit(in_enh, i_addr, ubrs_pkg::OFF_FLOW_OFF_TWO); // R3
  wire sel_mcr = hit(~in_enh, i_addr, ubrs_pkg::OFF_MODEM_CTRL);
  wire sel_tcr = hit(in_thr, i_addr, ubrs_pkg::OFF_THRESHOLD); // R5
  wire sel_tlr = hit(in_thr, i_addr, ubrs_pkg::OFF_TRIGGER); // R6
  wire sel_frr = hit(rdy_bank & ~lcr_div, i_addr, ubrs_pkg::OFF_READY); // R7
  wire sel_own = sel_lcr | sel_dll | sel_dlm | sel_efr | sel_on1 | sel_off1 | sel_on2
                 | sel_off2 | sel_mcr | sel_tcr | sel_tlr;
  wire wr_base = wr_en & ~sel_own; // R13
  wire rd_base = rd_en & ~sel_own & ~sel_frr; // R13

  ////////////////////////////////////////////////////////////////////////////
  // Read selection
  wire [7:0] rd_mux =
    sel_lcr ? lcr_r :
    sel_dll ? dll_r :
    sel_dlm ? dlm_r :
    sel_efr ? efr_r :
    sel_on1 ? on1_r :
    sel_on2 ? on2_r :
    sel_off1 ? off1_r :
    sel_off2 ? off2_r :
    sel_mcr ? mcr_r :
    sel_tcr ? tcr_r :
    sel_tlr ? tlr_r : // R6
    sel_frr ? i_fifo_rdy : // R7
    i_base_rdata; // R13

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      lcr_r <= ubrs_pkg::RST_REG;
      mcr_r <= ubrs_pkg::RST_REG;
      efr_r <= ubrs_pkg::RST_REG;
      dll_r <= ubrs_pkg::RST_REG;
      dlm_r <= ubrs_pkg::RST_REG;
      on1_r <= ubrs_pkg::RST_REG;
      on2_r <= ubrs_pkg::RST_REG;
      off1_r <= ubrs_pkg::RST_REG;
      off2_r <= ubrs_pkg::RST_REG;
      tcr_r <= ubrs_pkg::RST_REG;
      tlr_r <= ubrs_pkg::RST_REG;
    end else if (wr_en) begin
      if (sel_lcr) lcr_r <= i_data;
      if (sel_mcr) mcr_r <= i_data;
      if (sel_efr) efr_r <= i_data; // R4
      if (sel_dll) dll_r <= i_data; // R1
      if (sel_dlm) dlm_r <= i_data; // R1
      if (sel_on1) on1_r <= i_data; // R2
      if (sel_off1) off1_r <= i_data; // R2
      if (sel_on2) on2_r <= i_data; // R3
      if (sel_off2) off2_r <= i_data; // R3
      if (sel_tcr) tcr_r <= i_data; // R5
      if (sel_tlr) tlr_r <= i_data; // R6
    end
  end

  // Registered read answer
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      rdata_r <= ubrs_pkg::RST_REG;
      oe_r <= 1'b0;
    end else begin
      rdata_r <= rd_en ? rd_mux : rdata_r;
      oe_r <= rd_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_data = rdata_r;
  assign o_data_oe = oe_r;
  assign o_base_wr = wr_base;
  assign o_base_rd = rd_base;
  assign o_base_addr = i_addr;
  assign o_line_control = lcr_r;
  assign o_modem_control = mcr_r;
  assign o_enhanced_feature_ctrl = efr_r;
  assign o_baud_divisor = {dlm_r, dll_r};
  assign o_flow_on_char_one = on1_r;
  assign o_flow_on_char_two = on2_r;
  assign o_flow_off_char_one = off1_r;
  assign o_flow_off_char_two = off2_r;
  assign o_flow_threshold_ctrl = tcr_r;
  assign o_fifo_trigger_levels = tlr_r;
  assign o_bank = bank;

  ////////////////////////////////////////////////////////////////////////////
  // Infrared decoder
  ubrs_ir_if ir ();
  assign ir.os_tick = i_os_tick;
  assign o_int_rx = ir.int_rx; // R11

  ubrs_ir_decoder u_dec (
    .i_sys_clk (i_sys_clk),
    .i_rst_b (i_rst_b),
    .i_rx (i_rx),
    .ir (ir)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  property p_div;
    wr_en && lcr_r == 8'h80 && i_addr == ubrs_pkg::OFF_DIV_LOW
      |=> o_baud_divisor[7:0] == $past(i_data) && o_baud_divisor[15:8] == $past(dlm_r);
  endproperty
  a_div: assert property (p_div) else $error("Divisor low not written"); // R1

  property p_enh_one;
    wr_en && lcr_enh && (i_addr == 3'h6 || i_addr == 3'h4) |=>
      (($past(i_addr) == 3'h6) ? o_flow_off_char_one : o_flow_on_char_one) == $past(i_data);
  endproperty
  a_enh_one: assert property (p_enh_one) else $error("First flow char not written"); // R2

  property p_enh_two;
    rd_en && lcr_enh && i_addr == 3'h7 |=> o_data == $past(off2_r) && o_data_oe;
  endproperty
  a_enh_two: assert property (p_enh_two) else $error("Second off char not read"); // R3

  property p_efr;
    wr_en && lcr_enh && i_addr == 3'h2 |=> o_enhanced_feature_ctrl == $past(i_data)
      && o_line_control == 8'hbf;
  endproperty
  a_efr: assert property (p_efr) else $error("Enhanced control not written"); // R4

  property p_tcr;
    wr_en && efr_r[4] && mcr_r[6] && !lcr_enh && !lcr_div && i_addr == 3'h6
      |=> o_flow_threshold_ctrl == $past(i_data) && o_flow_off_char_one == $past(off1_r);
  endproperty
  a_tcr: assert property (p_tcr) else $error("Threshold not written"); // R5

  property p_tlr;
    rd_en && efr_r[4] && mcr_r[6] && !lcr_enh && !lcr_div && i_addr == 3'h7
      |=> o_data == $past(tlr_r);
  endproperty
  a_tlr: assert property (p_tlr) else $error("Trigger levels not read"); // R6

  property p_frr;
    rd_en && efr_r[4] && !mcr_r[6] && !lcr_r[7] && i_addr == 3'h7
      |=> o_data == $past(i_fifo_rdy) && !$past(o_base_rd);
  endproperty
  a_frr: assert property (p_frr) else $error("FIFO ready not returned"); // R7

  property p_base;
    wr_en && !lcr_r[7] && !efr_r[4] && i_addr != 3'h3 && i_addr != 3'h4
      |-> o_base_wr ##1 o_baud_divisor == $past(o_baud_divisor);
  endproperty
  a_base: assert property (p_base) else $error("Base fall-through missed"); // R13

  c_div: cover property (wr_en && in_div && sel_dll);
  c_enh: cover property (wr_en && sel_off2);
  c_thr: cover property (wr_en && sel_tcr ##[1:50] rd_en && sel_tlr);
  c_frr: cover property (rd_en && sel_frr);

endmodule

// *** inc/ubrs_ir_if.sv ***
// Link between the register block and its infrared receive decoder.
// Assumes both ends run on the same system clock.
interface ubrs_ir_if;
  logic os_tick;
  logic int_rx;
  modport dec (input os_tick, output int_rx);
  modport top (output os_tick, input int_rx);
endinterface

// *** inc/ubrs_pkg.sv ***
// Constants shared by the banked register block and its infrared decoder.
// Assumes an 8-bit host bus with three address bits and one system clock.
package ubrs_pkg;

  // Address offsets
  localparam logic [2:0] OFF_DIV_LOW = 3'h0;
  localparam logic [2:0] OFF_DIV_HIGH = 3'h1;
  localparam logic [2:0] OFF_ENH_CTRL = 3'h2;
  localparam logic [2:0] OFF_LINE_CTRL = 3'h3;
  localparam logic [2:0] OFF_MODEM_CTRL = 3'h4;
  localparam logic [2:0] OFF_FLOW_ON_ONE = 3'h4;
  localparam logic [2:0] OFF_FLOW_ON_TWO = 3'h5;
  localparam logic [2:0] OFF_FLOW_OFF_ONE = 3'h6;
  localparam logic [2:0] OFF_THRESHOLD = 3'h6;
  localparam logic [2:0] OFF_FLOW_OFF_TWO = 3'h7;
  localparam logic [2:0] OFF_TRIGGER = 3'h7;
  localparam logic [2:0] OFF_READY = 3'h7;

  // Bank selection values and field positions
  localparam logic [7:0] LCR_ENH_BANK = 8'hbf;
  localparam int LCR_DIV_BIT = 7;
  localparam int EFR_ENH_BIT = 4;
  localparam int MCR_BANK_BIT = 6;

  // Values after reset
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [3:0] RST_CNT = 4'h0;

  // Infrared decoder: oversampling ticks per bit
  localparam int IR_BIT_TICKS = 16;
  localparam logic [3:0] IR_LAST_TICK = 4'(IR_BIT_TICKS - 1);

  // Register bank in force
  typedef enum logic [1:0] {
    UBRS_BANK_BASE = 2'b00,
    UBRS_BANK_DIV = 2'b01,
    UBRS_BANK_ENH = 2'b10,
    UBRS_BANK_THR = 2'b11
  } ubrs_bank_t;

endpackage

// *** sim/ubrs_host_model.sv ***
// Host processor model: drives the 8-bit bus one access at a time.
// Assumes the device takes a strobe at each rising edge of i_sys_clk.
module ubrs_host_model (
  // Clock
  input wire logic i_sys_clk,
  // Bus to the device
  output logic o_cs_b,
  output logic o_wr_b,
  output logic o_rd_b,
  output logic [2:0] o_addr,
  output logic [7:0] o_data,
  input wire logic [7:0] i_data,
  input wire logic i_data_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] saved_line_r;
  initial begin
    o_cs_b = 1'b1;
    o_wr_b = 1'b1;
    o_rd_b = 1'b1;
    o_addr = 3'h0;
    o_data = 8'h00;
  end
  ////////////////////////////////////////
  // One access, read result taken at the answer edge
  task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic oe);
    @(posedge i_sys_clk);
    #5;
    o_cs_b = 1'b0;
    o_wr_b = ~wr;
    o_rd_b = wr;
    o_addr = a;
    o_data = d;
    @(posedge i_sys_clk);
    #5;
    q = i_data;
    oe = i_data_oe;
    o_cs_b = 1'b1;
    o_wr_b = 1'b1;
    o_rd_b = 1'b1;
    o_addr = ~o_addr;
    o_data = ~o_data;
  endtask
  // Save line control, then switch bank
  task automatic open_bank(input logic [7:0] v);
    logic [7:0] q;
    logic oe;
    access(1'b0, 3'h3, 8'h00, saved_line_r, oe);
    access(1'b1, 3'h3, v, q, oe);
  endtask
  // Put the saved line control back
  task automatic close_bank();
    logic [7:0] q;
    logic oe;
    access(1'b1, 3'h3, saved_line_r, q, oe);
  endtask
endmodule

// *** sim/ubrs_regbank_bench.sv ***
// Bench for the banked register block: host accesses and infrared decode.
// Assumes the host model and a base set that returns 8'hc0 plus the offset.
module ubrs_regbank_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic os_tick = 1'b0;
  logic rx = 1'b1;
  int cyc = 0;
  int miscompares = 0;
  int comparisons = 0;
  int base_wrs = 0;
  int base_rds = 0;
  wire logic base_wr, base_rd;
  wire logic cs_b, wr_b, rd_b, oe;
  wire logic [2:0] addr, base_addr;
  wire logic [7:0] wdata, rdata;
  wire logic [7:0] base_rdata = {5'h18, base_addr};
  logic [7:0] line_c, modem_c, enh_c, on1, on2, off1, off2, thr, trig;
  logic [15:0] div;
  logic [1:0] bank;
  logic int_rx;
  always #25 i_sys_clk = ~i_sys_clk;
  ubrs_host_model u_host (.i_sys_clk(i_sys_clk), .o_cs_b(cs_b), .o_wr_b(wr_b),
    .o_rd_b(rd_b), .o_addr(addr), .o_data(wdata), .i_data(rdata), .i_data_oe(oe));
  ubrs_regbank u_dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_cs_b(cs_b),
    .i_wr_b(wr_b), .i_rd_b(rd_b), .i_addr(addr), .i_data(wdata), .o_data(rdata),
    .o_data_oe(oe), .o_base_wr(base_wr), .o_base_rd(base_rd), .o_base_addr(base_addr),
    .i_base_rdata(base_rdata), .i_fifo_rdy(8'h5a), .o_line_control(line_c),
    .o_modem_control(modem_c), .o_enhanced_feature_ctrl(enh_c),
    .o_baud_divisor(div), .o_flow_on_char_one(on1), .o_flow_on_char_two(on2),
    .o_flow_off_char_one(off1), .o_flow_off_char_two(off2),
    .o_flow_threshold_ctrl(thr), .o_fifo_trigger_levels(trig), .o_bank(bank),
    .i_os_tick(os_tick), .i_rx(rx), .o_int_rx(int_rx));
  ////////////////////////////////////////
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic o;
    u_host.access(1'b1, a, d, q, o);
  endtask
  // Read checks the enable flag and the data together
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic o;
    u_host.access(1'b0, a, 8'h00, q, o);
    chk(16'({o, q}), {8'h01, exp});
  endtask
  // Wait for a decoded zero, then measure how long it stays low
  task automatic ir_zero();
    int n;
    n = 0;
    while (int_rx !== 1'b0 && n < 12) begin
      @(posedge i_sys_clk);
      #5;
      n++;
    end
    chk(16'(int_rx), 16'h0000);
    n = 0;
    while (int_rx === 1'b0 && n < 100) begin
      @(posedge i_sys_clk);
      #5;
      n++;
    end
    chk(16'(n), 16'h0040);
  endtask
  ////////////////////////////////////////
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    base_wrs <= base_wrs + int'(base_wr);
    base_rds <= base_rds + int'(base_rd);
    os_tick <= #5 (cyc[1:0] == 2'h3);
    if (cyc == 2000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge i_sys_clk);
    #5;
    i_rst_b = 1'b1;
    chk({line_c, modem_c}, 16'h0000);
    chk(16'({int_rx, oe, bank}), 16'h0008);
    u_host.open_bank(8'h80);
    chk(16'(bank), 16'h0001);
    wr(3'h0, 8'h34);
    wr(3'h1, 8'h12);
    chk(div, 16'h1234);
    rd(3'h1, 8'h12);
    u_host.close_bank();
    chk({line_c, 6'h00, bank}, 16'h0000);
    wr(3'h0, 8'h77);
    chk(div, 16'h1234);
    rd(3'h5, 8'hc5);
    u_host.open_bank(8'hbf);
    wr(3'h6, 8'ha1);
    wr(3'h4, 8'ha2);
    wr(3'h7, 8'ha3);
    wr(3'h5, 8'ha4);
    wr(3'h2, 8'h10);
    chk({off1, on1}, 16'ha1a2);
    chk({off2, on2}, 16'ha3a4);
    chk({enh_c, modem_c}, 16'h1000);
    rd(3'h7, 8'ha3);
    rd(3'h2, 8'h10);
    wr(3'h3, 8'h00);
    wr(3'h4, 8'h40);
    chk(16'(bank), 16'h0003);
    wr(3'h6, 8'hb6);
    wr(3'h7, 8'hb7);
    chk({thr, off1}, 16'hb6a1);
    chk({trig, off2}, 16'hb7a3);
    rd(3'h6, 8'hb6);
    rd(3'h7, 8'hb7);
    wr(3'h4, 8'h00);
    rd(3'h7, 8'h5a);
    wr(3'h7, 8'h99);
    chk({trig, off2}, 16'hb7a3);
    u_host.open_bank(8'hbf);
    wr(3'h2, 8'h00);
    u_host.close_bank();
    rd(3'h7, 8'hc7);
    chk(16'({base_wrs[7:0], base_rds[7:0]}), 16'h0202);
    rx = 1'b0;
    ir_zero();
    rx = 1'b1;
    repeat (10) @(posedge i_sys_clk);
    #5;
    chk(16'(int_rx), 16'h0001);
    rx = 1'b0;
    ir_zero();
    print_verdict();
  end
endmodule
